/* File: hw/rbr_map.svh */
// offsets, field classes, reset values and timing counts of the reserved bit register
`ifndef RBR_MAP_SVH
`define RBR_MAP_SVH
`define RBR_WIDTH      32
// per-bit class masks of the demonstration register
`define RBR_FUNC_MASK  32'h0000_00ff
`define RBR_CTXZ_MASK  32'h0000_0f00
`define RBR_HWONE_MASK 32'h0000_3000
`define RBR_WRONE_MASK 32'h0000_c000
`define RBR_CTXO_MASK  32'h000f_0000
// both context fields together, for checks that treat them alike
`define RBR_CTXBOTH_MASK 32'h000f_0f00
`define RBR_MIXED_MASK 32'h00f0_0000
`define RBR_HWZERO_MASK 32'hff00_0000
// reset value: reserved ones reset to one, others zero
`define RBR_RESET_VAL  32'h000f_f000
// reset images of the registered read word, read-only word and function view
`define RBR_RD_RESET   32'h000f_f000
`define RBR_RO_RESET   32'h0000_0200
`define RBR_FUNC_RESET 16'h0000
// read-only status word: low byte live, bit 8 reserved-as-zero, bit 9 reserved-as-one
`define RBR_RO_ONE_POS 9
`define RBR_RO_ZERO_POS 8
`define RBR_READ_LAT   1
`endif

/* File: hw/rbr_pkg.sv */
// types shared by the reserved bit register design
package rbr_pkg;
    typedef enum logic [1:0] {
        RBR_OP_IDLE,
        RBR_OP_DIRECT,
        RBR_OP_INDIRECT
    } rbr_op_t;
endpackage : rbr_pkg

/* File: hw/rbr_if.sv */
// carrier between the register bank and its read-back mux
`timescale 1ns/1ps
interface rbr_if;
    logic [31:0] store;
    logic [31:0] rdata;
    modport bank (output store, input rdata);
    modport mux  (input store, output rdata);
endinterface : rbr_if

/* File: hw/rbr_rdmux.sv */
// read-back value of the register, the same in every context
`timescale 1ns/1ps
`include "rbr_map.svh"
module rbr_rdmux import rbr_pkg::*; (
    rbr_if.mux m
);
    // hardwired bits ignore storage; mixed bits read what was stored
    always_comb begin
        m.rdata = (m.store & ~`RBR_HWONE_MASK & ~`RBR_HWZERO_MASK) | `RBR_HWONE_MASK;
    end
endmodule : rbr_rdmux

/* File: hw/rbr_ro.sv */
// read-only status word with reserved bits held constant
`timescale 1ns/1ps
`include "rbr_map.svh"
module rbr_ro import rbr_pkg::*; (
    input  wire logic [7:0]  live,
    output logic      [31:0] value
);
    // low byte live, bit 8 zero, bit 9 one, rest zero
    always_comb begin
        value = {22'h0, 1'b1, 1'b0, live};
    end
endmodule : rbr_ro

/* File: hw/rbr_top.sv */
// register with functional and reserved bits of every documented class
// Overview of operation
// - indirect write in reserved context clears context reserved-zero bits.
// - context reserved bits read last value written, whatever the context then.
// - unwritten bits read their reset value.
// - direct writes update storage of writable reserved bits.
// - reserved-context bit values do not reach the functional output.
// - zero-in-one, one-in-other bits are writable and read back.
// - read-only reserved-zero bit reads zero.
// - hardwired reserved-one bits read one and ignore writes.
// - indirect write sets writable reserved-one bits to one, and context reserved-one bits only in reserved context.
// - each reserved-one field chooses hardwired or writable separately.
// - read-only reserved-one bit reads one.
// - reserved marking of a field applies to each bit.
`timescale 1ns/1ps
`include "rbr_map.svh"
module rbr_top import rbr_pkg::*; (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        wr_direct,
    input  wire logic        wr_indirect,
    input  wire logic [31:0] wdata,
    input  wire logic        ctx_reserved,
    input  wire logic [7:0]  status_live,
    output logic      [31:0] rdata,
    output logic      [31:0] ro_rdata,
    output logic      [15:0] func_out
);
    // all state: storage, registered read views and the functional view
    typedef struct packed {
        logic [31:0] store;
        logic [31:0] rd;
        logic [31:0] ro;
        logic [15:0] func;
    } rbr_state_t;

    rbr_state_t st_ff;
    rbr_state_t nxt_st;
    logic [31:0] mux_rdata;
    logic [31:0] ro_value;
    rbr_op_t     op;

    // storage goes out to the read mux; reads never depend on the context
    rbr_if bus ();
    assign bus.store = st_ff.store;
    assign mux_rdata = bus.rdata;

    // read-back view and read-only word are built in their own modules
    rbr_rdmux u_rdmux (
        .m (bus.mux)
    );

    rbr_ro u_ro (
        .live  (status_live),
        .value (ro_value)
    );

    // indirect write takes priority over a direct write in the same cycle
    function automatic rbr_op_t decode_op(input logic d, input logic i);
        if (i) begin
            return RBR_OP_INDIRECT;
        end
        return d ? RBR_OP_DIRECT : RBR_OP_IDLE;
    endfunction : decode_op

    // merge a write into storage, every mask bit handled on its own
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [31:0] mask);
        return (old & ~mask) | (nv & mask);
    endfunction : merge

    assign op = decode_op(wr_direct, wr_indirect);

    // next state: storage update and registered read data
    always_comb begin
        logic [31:0] wmask;
        logic [31:0] cz;
        logic [31:0] co;
        wmask  = 32'h0;
        cz     = 32'h0;
        co     = 32'h0;
        nxt_st = st_ff;
        // hardwired fields never take writes; each one-field picks its own style
        wmask = `RBR_FUNC_MASK | `RBR_CTXZ_MASK | `RBR_WRONE_MASK
              | `RBR_CTXO_MASK | `RBR_MIXED_MASK;
        cz = ctx_reserved ? `RBR_CTXZ_MASK : 32'h0;
        co = ctx_reserved ? `RBR_CTXO_MASK : 32'h0;
        case (op)
            RBR_OP_DIRECT: begin
                nxt_st.store = merge(st_ff.store, wdata, wmask);
            end
            RBR_OP_INDIRECT: begin
                nxt_st.store = merge(st_ff.store, wdata, wmask & ~cz & ~co & ~`RBR_WRONE_MASK);
                nxt_st.store = nxt_st.store & ~cz;
                nxt_st.store = nxt_st.store | co | `RBR_WRONE_MASK;
            end
            RBR_OP_IDLE: begin
                nxt_st.store = st_ff.store;
            end
            default: begin
                nxt_st.store = st_ff.store;
            end
        endcase
        nxt_st.rd = mux_rdata;
        nxt_st.ro = ro_value;
        // in reserved context both context fields are masked off the function
        nxt_st.func = {ctx_reserved ? 4'h0 : st_ff.store[11:8],
                       ctx_reserved ? 4'h0 : st_ff.store[19:16],
                       st_ff.store[7:0]};
    end

    // one register stage for all state; reset gives the documented reset value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{store: `RBR_RESET_VAL, rd: `RBR_RD_RESET, ro: `RBR_RO_RESET,
                       func: `RBR_FUNC_RESET};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs come straight from the state register
    assign rdata    = st_ff.rd;
    assign ro_rdata = st_ff.ro;
    assign func_out = st_ff.func;

    // checks of storage, read-back and functional view
    // write kinds seen at a clock edge; the checks down to a_wrone_read start from these
    sequence s_direct;
        op == RBR_OP_DIRECT;
    endsequence

    sequence s_indirect;
        op == RBR_OP_INDIRECT;
    endsequence

    sequence s_ind_ctx;
        op == RBR_OP_INDIRECT && ctx_reserved;
    endsequence

    sequence s_ind_free;
        op == RBR_OP_INDIRECT && !ctx_reserved;
    endsequence

    // context zero bits are cleared by an indirect write in reserved use
    a_indirect_zero: assert property (@(posedge clk) disable iff (!nrst)
        s_ind_ctx
        |=> ((st_ff.store & `RBR_CTXZ_MASK) == 32'h0))
        else $error("context zero bits not cleared");

    // writable one bits are forced by any indirect write
    a_indirect_one: assert property (@(posedge clk) disable iff (!nrst)
        s_indirect
        |=> ((st_ff.store & `RBR_WRONE_MASK) == `RBR_WRONE_MASK))
        else $error("writable one bits not set");

    // context one bits are forced by an indirect write in reserved use
    a_ctx_one_set: assert property (@(posedge clk) disable iff (!nrst)
        s_ind_ctx
        |=> ((st_ff.store & `RBR_CTXO_MASK) == `RBR_CTXO_MASK))
        else $error("context one bits not set");

    // outside reserved use an indirect write stores the context fields
    a_ind_keeps_data: assert property (@(posedge clk) disable iff (!nrst)
        s_ind_free
        |=> ((st_ff.store & `RBR_CTXBOTH_MASK) == ($past(wdata) & `RBR_CTXBOTH_MASK)))
        else $error("indirect write lost context data");

    // direct write lands in the mixed bits
    a_direct_store: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ((st_ff.store & `RBR_MIXED_MASK) == ($past(wdata) & `RBR_MIXED_MASK)))
        else $error("direct write not stored");

    // direct write lands in the context fields whatever the context
    a_direct_ctx_bits: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ((st_ff.store & `RBR_CTXBOTH_MASK) == ($past(wdata) & `RBR_CTXBOTH_MASK)))
        else $error("direct write missed context bits");

    // writable one field takes a direct write, zeros included
    a_direct_one_bits: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ((st_ff.store & `RBR_WRONE_MASK) == ($past(wdata) & `RBR_WRONE_MASK)))
        else $error("direct write missed one field");

    // functional byte is merged bit by bit
    a_direct_func: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ((st_ff.store & `RBR_FUNC_MASK) == ($past(wdata) & `RBR_FUNC_MASK)))
        else $error("direct write missed function bits");

    // two edges after a direct write the read shows the context zero bits
    a_readback_two: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ##1 ((rdata & `RBR_CTXZ_MASK) == ($past(wdata, 2) & `RBR_CTXZ_MASK)))
        else $error("read back differs from written");

    // mixed bits read back the last direct write
    a_mixed_read: assert property (@(posedge clk) disable iff (!nrst)
        s_direct
        |=> ##1 ((rdata & `RBR_MIXED_MASK) == ($past(wdata, 2) & `RBR_MIXED_MASK)))
        else $error("mixed bits read back wrong");

    // mixed bits are plain storage for indirect writes too
    a_mixed_indirect: assert property (@(posedge clk) disable iff (!nrst)
        s_indirect
        |=> ((st_ff.store & `RBR_MIXED_MASK) == ($past(wdata) & `RBR_MIXED_MASK)))
        else $error("mixed bits lost indirect data");

    // the forced zeros reach the read two edges later
    a_ctx_zero_read: assert property (@(posedge clk) disable iff (!nrst)
        s_ind_ctx
        |=> ##1 ((rdata & `RBR_CTXZ_MASK) == 32'h0))
        else $error("forced zeros not read back");

    // the forced context ones reach the read two edges later
    a_ctx_one_read: assert property (@(posedge clk) disable iff (!nrst)
        s_ind_ctx
        |=> ##1 ((rdata & `RBR_CTXO_MASK) == `RBR_CTXO_MASK))
        else $error("forced context ones not read back");

    // the forced writable ones reach the read two edges later
    a_wrone_read: assert property (@(posedge clk) disable iff (!nrst)
        s_indirect
        |=> ##1 ((rdata & `RBR_WRONE_MASK) == `RBR_WRONE_MASK))
        else $error("forced ones not read back");

    // hardwired bits always read their fixed level
    a_hw_one_read: assert property (@(posedge clk) disable iff (!nrst)
        ((rdata & `RBR_HWONE_MASK) == `RBR_HWONE_MASK)
        && ((rdata & `RBR_HWZERO_MASK) == 32'h0))
        else $error("hardwired bits wrong");

    // hardwired bits never move in storage either, so no write can leak in
    a_hw_store_fixed: assert property (@(posedge clk) disable iff (!nrst)
        ((st_ff.store & `RBR_HWONE_MASK) == `RBR_HWONE_MASK)
        && ((st_ff.store & `RBR_HWZERO_MASK) == 32'h0))
        else $error("hardwired storage moved");

    // read word is the stored word of the edge before, hardwired bits on top
    a_read_view: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> (rdata == (($past(st_ff.store) & ~`RBR_HWZERO_MASK) | `RBR_HWONE_MASK)))
        else $error("read word differs from storage");

    // leaving reset, storage holds the reset value
    a_reset_store: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst)
        |-> (st_ff.store == `RBR_RESET_VAL))
        else $error("storage not at reset value");

    // an unwritten register reads its reset value
    a_reset_read: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst)
        |=> (rdata == `RBR_RD_RESET))
        else $error("unwritten read not reset value");

    // read-only word: fixed one and fixed zero positions
    a_ro_bits: assert property (@(posedge clk) disable iff (!nrst)
        ro_rdata[`RBR_RO_ONE_POS]
        && !ro_rdata[`RBR_RO_ZERO_POS])
        else $error("read-only reserved bits wrong");

    // read-only low byte follows the live status one edge later
    a_ro_live: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> (ro_rdata[7:0] == $past(status_live)))
        else $error("read-only status byte wrong");

    // read-only word above the fixed bits reads zero
    a_ro_upper: assert property (@(posedge clk) disable iff (!nrst)
        ro_rdata[31:10] == 22'h0)
        else $error("read-only upper bits not zero");

    // in reserved use no context bit reaches the function
    a_no_effect: assert property (@(posedge clk) disable iff (!nrst)
        $past(ctx_reserved)
        |-> (func_out[15:8] == 8'h00))
        else $error("reserved bits reached function");

    // outside reserved use the context fields drive the function
    a_func_view: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && !$past(ctx_reserved)
        |-> (func_out[15:8] == {$past(st_ff.store[11:8]), $past(st_ff.store[19:16])}))
        else $error("context fields missing from function");

    // functional byte always follows storage
    a_func_low: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> (func_out[7:0] == $past(st_ff.store[7:0])))
        else $error("function byte differs from storage");

    // storage only changes on a write
    a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
        op == RBR_OP_IDLE
        |=> $stable(st_ff.store))
        else $error("storage changed without write");

    // both strobes at once act as an indirect write
    a_ind_wins: assert property (@(posedge clk) disable iff (!nrst)
        wr_direct && wr_indirect
        |=> ((st_ff.store & `RBR_WRONE_MASK) == `RBR_WRONE_MASK))
        else $error("direct write won over indirect");
endmodule : rbr_top

/* File: verification/tb_rbr_top.sv */
// self-checking bench of the reserved bit register
`timescale 1ns/1ps
module tb_rbr_top;
    logic        clk = 1'b0;
    logic        nrst;
    logic        wr_direct;
    logic        wr_indirect;
    logic [31:0] wdata;
    logic        ctx_reserved;
    logic [7:0]  status_live;
    logic [31:0] rdata;
    logic [31:0] ro_rdata;
    logic [15:0] func_out;
    int          num_errors = 0;
    int          total_checks = 0;
    // free-running 100 mhz clock
    always #5 clk = ~clk;
    rbr_top DUT (
        .clk          (clk),
        .nrst         (nrst),
        .wr_direct    (wr_direct),
        .wr_indirect  (wr_indirect),
        .wdata        (wdata),
        .ctx_reserved (ctx_reserved),
        .status_live  (status_live),
        .rdata        (rdata),
        .ro_rdata     (ro_rdata),
        .func_out     (func_out)
    );
    // case equality, so an unknown never counts as a match
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: value %h expected %h", $time, got, exp);
        end
    endtask : check
    // one strobe cycle, then wait until the read-back path has settled
    task automatic write_op(input logic dir, input logic ind, input logic ctx,
                            input logic [31:0] data);
        @(posedge clk);
        wr_direct <= dir;
        wr_indirect <= ind;
        ctx_reserved <= ctx;
        wdata <= data;
        @(posedge clk);
        wr_direct <= 1'b0;
        wr_indirect <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : write_op
    task automatic test_reset();
        check(rdata, 32'h000f_f000);
        check(ro_rdata, 32'h0000_0200);
        check({16'h0000, func_out}, 32'h0000_0f00);
    endtask : test_reset
    // hardwired bits written with the wrong value must not move
    task automatic test_direct();
        write_op(1'b1, 1'b0, 1'b1, 32'hff55_0faa);
        check(rdata, 32'h0055_3faa);
        check({16'h0000, func_out}, 32'h0000_00aa);
        @(posedge clk);
        ctx_reserved <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({16'h0000, func_out}, 32'h0000_f5aa);
        check(rdata, 32'h0055_3faa);
    endtask : test_direct
    // forced bits differ between the two contexts
    task automatic test_indirect();
        write_op(1'b0, 1'b1, 1'b1, 32'h00a0_0a55);
        check(rdata, 32'h00af_f055);
        check({16'h0000, func_out}, 32'h0000_0055);
        write_op(1'b0, 1'b1, 1'b0, 32'h0000_0a55);
        check(rdata, 32'h0000_fa55);
        check({16'h0000, func_out}, 32'h0000_a055);
        // software preserves reserved bits read back
        write_op(1'b1, 1'b0, 1'b0, {rdata[31:8], 8'h3c});
        check(rdata, 32'h0000_fa3c);
        // both strobes together: the indirect write takes effect
        write_op(1'b1, 1'b1, 1'b1, 32'h0000_0f00);
        check(rdata, 32'h000f_f000);
        check({16'h0000, func_out}, 32'h0000_0000);
    endtask : test_indirect
    // a second reset in mid-run must bring back the reset image
    task automatic test_mid_reset();
        write_op(1'b1, 1'b0, 1'b0, 32'h00aa_5a5a);
        check(rdata, 32'h00aa_7a5a);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        check(rdata, 32'h000f_f000);
        check({16'h0000, func_out}, 32'h0000_0000);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(rdata, 32'h000f_f000);
        check({16'h0000, func_out}, 32'h0000_0f00);
    endtask : test_mid_reset
    task automatic test_ro();
        logic [7:0] vals [3];
        vals = '{8'h00, 8'ha5, 8'hff};
        foreach (vals[i]) begin
            @(posedge clk);
            status_live <= vals[i];
            repeat (2) @(posedge clk);
            #1;
            check(ro_rdata, {22'h00_0000, 2'b10, vals[i]});
        end
    endtask : test_ro
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // the run needs well under 200 cycles; a hang ends here
    initial begin
        #20000;
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        nrst = 1'b0;
        wr_direct = 1'b0;
        wr_indirect = 1'b0;
        wdata = 32'h0000_0000;
        ctx_reserved = 1'b0;
        status_live = 8'h00;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        test_reset();
        test_direct();
        test_indirect();
        test_ro();
        test_mid_reset();
        stop_test();
    end
endmodule : tb_rbr_top
